// file: pcipm_ctrl.sv
// pm control/status word, bridge extension byte and axi4-lite slave
// Functional notes
// - wake status flag sets on every wake event, whatever the enable bit says.
// - writing one clears the wake status flag; writing zero leaves it.
// - status and enable reset to zero without cold wake, else sticky.
// - read-only scale field in bits 14..13 follows the data selection.
// - four-bit data selection field in bits 12..9.
// - scale and selection read zero when the data register is absent.
// - wake line is driven only while the enable bit is one.
// - power state field in bits 1..0: D0, D1, D2, D3hot.
// - writes of unsupported states complete but leave the state unchanged.
// - bridge extension byte is read-only, fixed by parameters, bit 7 enable.
// - bit 6 picks D3hot action: one stops clock, zero removes power.
// - D3hot action bit counts only while bit 7 is one.
// - strap level at power-on decides cold wake support and stickiness.
`include "pcipm_regs.svh"
`default_nettype none

module pcipm_ctrl
    import pcipm_pkg::*;
#(
    parameter int         ADDR_W         = 8,
    parameter bit         DATA_REG_IMPL  = 1'b0,
    parameter bit         D1_SUPPORTED   = 1'b1,
    parameter bit         D2_SUPPORTED   = 1'b1,
    parameter bit         BPCC_ENABLE    = 1'b0,
    parameter bit         D3HOT_CLK_STOP = 1'b0
) (
    // clock, resets and enable
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              pwr_on_reset,
    input  wire logic              ce,
    // axi4-lite write address
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // axi4-lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // axi4-lite read address
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // axi4-lite read data
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // function side
    input  wire logic              wake_event,
    input  wire logic              cold_wake_support_strap,
    input  wire logic [7:0]        data_value,
    input  wire logic [1:0]        data_scale_in,
    output logic [1:0]             power_state,
    output logic [3:0]             data_select_out,
    // secondary bus control
    output logic                   sec_bus_clk_stop,
    output logic                   sec_bus_pwr_off,
    // wake line, open drain
    input  wire logic              pme_n_in,
    output logic                   pme_n_out,
    output logic                   pme_n_oe_n,
    // interrupt
    output logic                   irq
);

    generate
        // the word index is cut from address bits 7..2, so narrower buses cannot work
        if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
            $error("pcipm_ctrl: ADDR_W must lie between 8 and 32");
        end
    endgenerate

    // index of an aligned word
    function automatic logic [5:0] word_index(input logic [ADDR_W-1:0] a);
        return a[7:2];
    endfunction

    // true for a mapped index
    function automatic logic index_mapped(input logic [5:0] i,
                                          input logic [ADDR_W-1:0] a);
        logic hi_zero;
        hi_zero = (a >> 8) == '0;
        return hi_zero && (i == `PCIPM_IDX_PM_CONTROL_STATUS || i == `PCIPM_IDX_BSE ||
                           i == `PCIPM_IDX_DATA || i == `PCIPM_IDX_IRQ_STATUS ||
                           i == `PCIPM_IDX_IRQ_MASK || i == `PCIPM_IDX_FUNC_STATUS);
    endfunction

    // true when the power state may be entered
    function automatic logic state_supported(input pcipm_pstate_t s);
        return (s == PCIPM_D0) || (s == PCIPM_D3HOT) ||
               (s == PCIPM_D1 && D1_SUPPORTED) || (s == PCIPM_D2 && D2_SUPPORTED);
    endfunction

    // strap capture
    logic cold_wake_supported;
    logic strap_taken;

    pcipm_strap_sampler u_strap (
        .clk                     (clk),
        .pwr_on_reset            (pwr_on_reset),
        .ce                      (ce),
        .cold_wake_support_strap (cold_wake_support_strap),
        .cold_wake_supported     (cold_wake_supported),
        .strap_taken             (strap_taken)
    );

    // register state
    logic          wake_event_status_flag;
    logic          wake_event_enable;
    logic [3:0]    data_select;
    pcipm_pstate_t power_state_field;
    logic [1:0]    irq_status;
    logic [1:0]    irq_mask;

    // bus state
    logic          aw_held;
    logic          w_held;
    pcipm_wreq_t   wreq;
    logic [ADDR_W-1:0] aw_addr_q;

    // write and read channel handshakes
    wire aw_take  = s_axi_awvalid && s_axi_awready;
    wire w_take   = s_axi_wvalid && s_axi_wready;
    wire do_write = aw_held && w_held && !s_axi_bvalid;
    wire b_done   = s_axi_bvalid && s_axi_bready;
    wire ar_take  = s_axi_arvalid && s_axi_arready;
    wire r_done   = s_axi_rvalid && s_axi_rready;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    // write decode
    wire w_mapped  = index_mapped(wreq.index, aw_addr_q);
    wire sel_pm_control_status = do_write && w_mapped && wreq.index == `PCIPM_IDX_PM_CONTROL_STATUS;
    wire sel_istat = do_write && w_mapped && wreq.index == `PCIPM_IDX_IRQ_STATUS;
    wire sel_imask = do_write && w_mapped && wreq.index == `PCIPM_IDX_IRQ_MASK;
    wire wr_byte0  = wreq.strb[0];
    wire wr_byte1  = wreq.strb[1];

    // control/status write effects
    wire           wake_clear = sel_pm_control_status && wr_byte1 &&
                                wreq.data[`PCIPM_BIT_WAKE_STATUS];
    wire           next_wake_status = wake_event ||
                                      (wake_event_status_flag && !wake_clear);
    wire           enable_write = sel_pm_control_status && wr_byte1;
    wire           sel_write = sel_pm_control_status && wr_byte1 && DATA_REG_IMPL;
    wire pcipm_pstate_t req_state =
        pcipm_pstate_t'(wreq.data[`PCIPM_PS_MSB:`PCIPM_PS_LSB]);
    // reserved bits 7..2 are ignored on write so a careless writer does no harm
    wire           ps_write = sel_pm_control_status && wr_byte0 && state_supported(req_state);
    wire           ps_change = ps_write && (req_state != power_state_field);

    // interrupt events; a set in the same cycle beats the clear
    wire [1:0] irq_events = {ps_change, wake_event && !wake_event_status_flag};
    wire [1:0] irq_clear  = sel_istat && wr_byte0 ? wreq.data[1:0] : 2'h0;
    wire [1:0] next_irq_status = irq_events | (irq_status & ~irq_clear);

    assign irq = |(irq_status & irq_mask);

    // sticky pair: function reset spares them only when cold wake is supported
    wire sticky_reset = reset && !cold_wake_supported;

    always_ff @(posedge clk) begin
        if (ce) begin
            if (pwr_on_reset || sticky_reset) begin
                wake_event_status_flag <= 1'b0;
                wake_event_enable      <= 1'b0;
            end else begin
                wake_event_status_flag <= next_wake_status;
                if (enable_write) begin
                    wake_event_enable <= wreq.data[`PCIPM_BIT_WAKE_ENABLE];
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (ce) begin
            if (pwr_on_reset || reset) begin
                data_select       <= 4'h0;
                power_state_field <= PCIPM_D0;
            end else begin
                if (sel_write) begin
                    data_select <= wreq.data[`PCIPM_SEL_MSB:`PCIPM_SEL_LSB];
                end
                if (ps_write) begin
                    power_state_field <= req_state;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (ce) begin
            if (pwr_on_reset || reset) begin
                irq_status <= `PCIPM_IRQ_RESET;
                irq_mask   <= `PCIPM_IRQ_RESET;
            end else begin
                irq_status <= next_irq_status;
                if (sel_imask && wr_byte0) begin
                    irq_mask <= wreq.data[1:0];
                end
            end
        end
    end

    // read view of the control/status word
    pcipm_pm_control_status_t pm_control_status_view;
    assign pm_control_status_view.wake_event_status_flag = wake_event_status_flag;
    assign pm_control_status_view.data_scale_factor = DATA_REG_IMPL ? data_scale_in : 2'h0;
    assign pm_control_status_view.data_select       = DATA_REG_IMPL ? data_select : 4'h0;
    assign pm_control_status_view.wake_event_enable = wake_event_enable;
    assign pm_control_status_view.reserved          = 6'h00;
    assign pm_control_status_view.power_state_field = power_state_field;

    // bridge extension byte is fixed by parameters; no write path exists
    pcipm_bse_t bse_view;
    assign bse_view.secondary_bus_pwr_clk_ctrl_en = BPCC_ENABLE;
    assign bse_view.d3hot_secondary_action        = D3HOT_CLK_STOP;
    assign bse_view.reserved                      = 6'h00;

    // read decode
    wire [5:0] r_index  = word_index(s_axi_araddr);
    wire       r_mapped = index_mapped(r_index, s_axi_araddr);
    logic [31:0] read_word;

    always_comb begin
        read_word = 32'h0000_0000;
        unique case (r_index)
            `PCIPM_IDX_PM_CONTROL_STATUS:       read_word = {16'h0000, pm_control_status_view};
            `PCIPM_IDX_BSE:         read_word = {24'h00_0000, bse_view};
            `PCIPM_IDX_DATA:        read_word = {24'h00_0000,
                                                 DATA_REG_IMPL ? data_value : 8'h00};
            `PCIPM_IDX_IRQ_STATUS:  read_word = {30'h0000_0000, irq_status};
            `PCIPM_IDX_IRQ_MASK:    read_word = {30'h0000_0000, irq_mask};
            `PCIPM_IDX_FUNC_STATUS: read_word = {29'h0000_0000, strap_taken,
                                                 !pme_n_in, cold_wake_supported};
            default:                read_word = 32'h0000_0000;
        endcase
    end

    // write channel capture; address and data may arrive in either order
    always_ff @(posedge clk) begin
        if (ce) begin
            if (pwr_on_reset || reset) begin
                aw_held   <= 1'b0;
                w_held    <= 1'b0;
                wreq      <= '0;
                aw_addr_q <= '0;
            end else begin
                if (aw_take) begin
                    aw_held    <= 1'b1;
                    aw_addr_q  <= s_axi_awaddr;
                    wreq.index <= word_index(s_axi_awaddr);
                end else if (do_write) begin
                    aw_held <= 1'b0;
                end
                if (w_take) begin
                    w_held    <= 1'b1;
                    wreq.data <= s_axi_wdata;
                    wreq.strb <= s_axi_wstrb;
                end else if (do_write) begin
                    w_held <= 1'b0;
                end
            end
        end
    end

    // write response one cycle after both halves are held
    always_ff @(posedge clk) begin
        if (ce) begin
            if (pwr_on_reset || reset) begin
                s_axi_bvalid <= 1'b0;
                s_axi_bresp  <= `PCIPM_RESP_OKAY;
            end else if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= w_mapped ? `PCIPM_RESP_OKAY : `PCIPM_RESP_SLVERR;
            end else if (b_done) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read data one cycle after the address is taken
    always_ff @(posedge clk) begin
        if (ce) begin
            if (pwr_on_reset || reset) begin
                s_axi_rvalid <= 1'b0;
                s_axi_rdata  <= 32'h0000_0000;
                s_axi_rresp  <= `PCIPM_RESP_OKAY;
            end else if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= read_word;
                s_axi_rresp  <= r_mapped ? `PCIPM_RESP_OKAY : `PCIPM_RESP_SLVERR;
            end else if (r_done) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // wake line: pulled low only when both flag and enable are set
    wire pme_assert = wake_event_status_flag && wake_event_enable;

    always_ff @(posedge clk) begin
        if (ce) begin
            if (pwr_on_reset) begin
                pme_n_oe_n <= 1'b1;
            end else begin
                pme_n_oe_n <= !pme_assert;
            end
        end
    end

    assign pme_n_out = 1'b0;

    // secondary bus action in D2 and D3hot; the action bit is ignored without the enable
    wire in_d3hot = power_state_field == PCIPM_D3HOT;
    wire bpcc_on  = bse_view.secondary_bus_pwr_clk_ctrl_en;

    always_ff @(posedge clk) begin
        if (ce) begin
            if (pwr_on_reset || reset) begin
                sec_bus_clk_stop <= 1'b0;
                sec_bus_pwr_off  <= 1'b0;
            end else begin
                sec_bus_clk_stop <= bpcc_on && ((in_d3hot && D3HOT_CLK_STOP) ||
                                    power_state_field == PCIPM_D2);
                sec_bus_pwr_off  <= bpcc_on && in_d3hot && !D3HOT_CLK_STOP;
            end
        end
    end

    assign power_state     = power_state_field;
    assign data_select_out = pm_control_status_view.data_select;

endmodule

`default_nettype wire

// file: pcipm_ctrl_assertions.sv
// port assertions for the pm control/status block
`default_nettype none

module pcipm_ctrl_assertions #(
    parameter bit D1_SUPPORTED  = 1'b1,
    parameter bit D2_SUPPORTED  = 1'b1,
    parameter bit DATA_REG_IMPL = 1'b0,
    parameter bit BPCC_ENABLE   = 1'b0
) (
    // clock and resets
    input wire logic       clk,
    input wire logic       reset,
    input wire logic       pwr_on_reset,
    input wire logic       ce,
    // bus and function side
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic       wake_event,
    input wire logic [1:0] power_state,
    input wire logic [3:0] data_select_out,
    input wire logic       sec_bus_clk_stop,
    input wire logic       sec_bus_pwr_off,
    input wire logic       pme_n_oe_n,
    input wire logic       irq
);
    wire logic w_take;

    assign w_take = s_axi_wvalid && s_axi_wready;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_oe_released_por: assert property (pwr_on_reset && ce |-> ##2 pme_n_oe_n)
        else $error("wake line driven after power-on reset");
    a_irq_clear_por: assert property (pwr_on_reset && ce |=> !irq)
        else $error("interrupt high after power-on reset");
    a_state_d0_por: assert property (pwr_on_reset && ce |=> power_state == 2'h0)
        else $error("power state not D0 after power-on reset");
    // a function reset does not reload the drive register but may alter the flag and enable behind it, hence the reset term
    a_oe_has_cause: assert property (
        $fell(pme_n_oe_n) |-> $past(wake_event, 2) || $past(w_take, 3)
            || $past(w_take, 4) || $past(reset, 2))
        else $error("wake line driven without event or enable write");
    a_select_absent: assert property (!DATA_REG_IMPL |-> data_select_out == 4'h0)
        else $error("data selection nonzero without data register");
    a_sec_bus_idle: assert property (
        !BPCC_ENABLE |-> !sec_bus_clk_stop && !sec_bus_pwr_off)
        else $error("secondary bus control active while disabled");
    a_state_supported: assert property (
        (D1_SUPPORTED || power_state != 2'h1) && (D2_SUPPORTED || power_state != 2'h2))
        else $error("unsupported power state entered");
    a_state_by_write: assert property (
        $changed(power_state) |-> $past(reset) || $past(pwr_on_reset)
            || $past(w_take, 2) || $past(w_take, 3))
        else $error("power state changed without a write");

    c_wake_driven: cover property ($fell(pme_n_oe_n));
    c_irq_raised: cover property ($rose(irq));
    c_state_d3hot: cover property (power_state == 2'h3);
endmodule

bind pcipm_ctrl pcipm_ctrl_assertions #(
    .D1_SUPPORTED (D1_SUPPORTED),
    .D2_SUPPORTED (D2_SUPPORTED),
    .DATA_REG_IMPL(DATA_REG_IMPL),
    .BPCC_ENABLE  (BPCC_ENABLE)
) chk_u (
    .clk             (clk),
    .reset           (reset),
    .pwr_on_reset    (pwr_on_reset),
    .ce              (ce),
    .s_axi_wvalid    (s_axi_wvalid),
    .s_axi_wready    (s_axi_wready),
    .wake_event      (wake_event),
    .power_state     (power_state),
    .data_select_out (data_select_out),
    .sec_bus_clk_stop(sec_bus_clk_stop),
    .sec_bus_pwr_off (sec_bus_pwr_off),
    .pme_n_oe_n      (pme_n_oe_n),
    .irq             (irq)
);

`default_nettype wire

// file: pcipm_ctrl_tb.sv
// self-checking bench for the pm control/status block
`default_nettype none
`include "pcipm_regs.svh"

`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
    $display("BAD t=%0t got %h exp %h", $time, (g), (e)); end end

module pcipm_ctrl_tb import pcipm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0] A_CS  = {`PCIPM_IDX_PM_CONTROL_STATUS, 2'h0};
    localparam logic [7:0] A_BSE = {`PCIPM_IDX_BSE, 2'h0};
    localparam logic [7:0] A_IST = {`PCIPM_IDX_IRQ_STATUS, 2'h0};
    localparam logic [7:0] A_IMK = {`PCIPM_IDX_IRQ_MASK, 2'h0};
    localparam logic [7:0] A_FST = {`PCIPM_IDX_FUNC_STATUS, 2'h0};
    localparam logic [1:0] OK    = `PCIPM_RESP_OKAY;

    logic        clk, reset, pwr_on_reset, ce, wake_event, strap;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rdat;
    logic [3:0]  wstrb, data_select_out;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [1:0]  bresp, rresp, power_state;
    logic        sec_bus_clk_stop, sec_bus_pwr_off, pme_n_out, pme_n_oe_n, irq;
    int          fail_count, samples_checked;
    // open-drain wake line with its pull-up
    wire logic   pme_line = pme_n_oe_n ? 1'b1 : pme_n_out;

    // d2 left out so that a discarded state write can be seen
    pcipm_ctrl #(.D2_SUPPORTED(1'b0)) dut_u (
        .clk(clk), .reset(reset), .pwr_on_reset(pwr_on_reset), .ce(ce),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .wake_event(wake_event),
        .cold_wake_support_strap(strap), .data_value(8'h00), .data_scale_in(2'h0),
        .power_state(power_state), .data_select_out(data_select_out),
        .sec_bus_clk_stop(sec_bus_clk_stop), .sec_bus_pwr_off(sec_bus_pwr_off),
        .pme_n_in(pme_line), .pme_n_out(pme_n_out), .pme_n_oe_n(pme_n_oe_n), .irq(irq)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic report_and_stop();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // handshakes are judged at the falling edge, where the slave's ready is settled
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        logic aw_t, w_t, b_t;
        b_t = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (!b_t) begin
            @(negedge clk);
            aw_t = (awvalid && awready) === 1'h1;
            w_t = (wvalid && wready) === 1'h1;
            b_t = bvalid === 1'h1;
            if (b_t) `CHK(bresp, er)
            @(posedge clk);
            if (aw_t) awvalid <= 1'h0;
            if (w_t) wvalid <= 1'h0;
            if (b_t) bready <= 1'h0;
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [1:0] er);
        logic ar_t, r_t;
        r_t = 1'b0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        while (!r_t) begin
            @(negedge clk);
            ar_t = (arvalid && arready) === 1'h1;
            r_t = rvalid === 1'h1;
            rdat = rdata;
            if (r_t) `CHK(rresp, er)
            @(posedge clk);
            if (ar_t) arvalid <= 1'h0;
            if (r_t) rready <= 1'h0;
        end
    endtask

    task automatic por(input logic s);
        @(posedge clk);
        strap <= s;
        pwr_on_reset <= 1'h1;
        repeat (6) @(posedge clk);
        pwr_on_reset <= 1'h0;
        repeat (2) @(posedge clk);
    endtask

    task automatic freset();
        @(posedge clk);
        reset <= 1'h1;
        @(posedge clk);
        reset <= 1'h0;
    endtask

    task automatic wake();
        @(posedge clk);
        wake_event <= 1'h1;
        @(posedge clk);
        wake_event <= 1'h0;
    endtask

    task automatic oe_is(input logic e);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (pme_n_oe_n !== e && n < 8);
        `CHK(pme_n_oe_n, e)
    endtask

    task automatic t_regs();
        rd(A_CS, OK);
        `CHK(rdat[15:0], `PCIPM_PM_CONTROL_STATUS_RESET)
        wr(A_BSE, 32'h0000_00FF, 4'hF, OK);
        rd(A_BSE, OK);
        `CHK(rdat[7:0], `PCIPM_BSE_RESET)
        rd(A_FST, OK);
        `CHK(rdat[2:0], 3'h4)
        wr(8'hFC, 32'hFFFF_FFFF, 4'hF, `PCIPM_RESP_SLVERR);
        rd(8'hFC, `PCIPM_RESP_SLVERR);
        `CHK(rdat, 32'h0000_0000)
    endtask

    task automatic t_pstate();
        logic [1:0] st [4];
        logic [1:0] ex;
        st = '{PCIPM_D1, PCIPM_D3HOT, PCIPM_D2, PCIPM_D0};
        ex = PCIPM_D0;
        for (int i = 0; i < 4; i++) begin
            wr(A_CS, {30'h0, st[i]}, 4'h1, OK);
            if (st[i] !== PCIPM_D2) ex = st[i];
            rd(A_CS, OK);
            `CHK(rdat[1:0], ex)
            @(negedge clk);
            `CHK(power_state, ex)
            `CHK({sec_bus_clk_stop, sec_bus_pwr_off}, 2'h0)
        end
        rd(A_IST, OK);
        `CHK(rdat[1:0], 2'h2)
        wr(A_IST, 32'h3, 4'h1, OK);
    endtask

    task automatic t_wake();
        wake();
        rd(A_CS, OK);
        `CHK({rdat[15], rdat[8]}, 2'h2)
        oe_is(1'h1);
        rd(A_IST, OK);
        `CHK(rdat[1:0], 2'h1)
        `CHK(irq, 1'h0)
        wr(A_IMK, 32'h1, 4'h1, OK);
        @(negedge clk);
        `CHK(irq, 1'h1)
        wr(A_IST, 32'h1, 4'h1, OK);
        @(negedge clk);
        `CHK(irq, 1'h0)
        wr(A_CS, 32'h0100, 4'h2, OK);
        oe_is(1'h0);
        rd(A_FST, OK);
        `CHK(rdat[1], 1'h1)
        wr(A_CS, 32'h0100, 4'h2, OK);
        rd(A_CS, OK);
        `CHK(rdat[15], 1'h1)
        wr(A_CS, 32'h8100, 4'h2, OK);
        oe_is(1'h1);
        rd(A_CS, OK);
        `CHK({rdat[15], rdat[8]}, 2'h1)
        wake();
        oe_is(1'h0);
        wr(A_CS, 32'h8000, 4'h2, OK);
        oe_is(1'h1);
        wr(A_IST, 32'h3, 4'h1, OK);
        wr(A_IMK, 32'h0, 4'h1, OK);
    endtask

    task automatic t_dsel();
        wr(A_CS, 32'h7E00, 4'h2, OK);
        rd(A_CS, OK);
        `CHK(rdat[14:9], 6'h00)
        @(negedge clk);
        `CHK(data_select_out, 4'h0)
    endtask

    // sticky bits survive a function reset only with cold wake supported
    task automatic t_sticky(input logic s);
        por(s);
        rd(A_FST, OK);
        `CHK(rdat[0], s)
        wake();
        wr(A_CS, 32'h0100, 4'h2, OK);
        freset();
        rd(A_CS, OK);
        `CHK({rdat[15], rdat[8]}, {s, s})
        oe_is(!s);
    endtask

    initial begin
        reset = 1'b1;
        pwr_on_reset = 1'b1;
        ce = 1'b1;
        wake_event = 1'b0;
        strap = 1'b0;
        {awaddr, araddr, wdata, wstrb} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        fail_count = 0;
        samples_checked = 0;
        repeat (6) @(posedge clk);
        reset <= 1'h0;
        pwr_on_reset <= 1'h0;
        t_regs();
        t_pstate();
        t_wake();
        t_dsel();
        t_sticky(1'h1);
        t_sticky(1'h0);
        report_and_stop();
    end

    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        report_and_stop();
    end
endmodule

`default_nettype wire

// file: pcipm_pkg.sv
// types shared by the pm control block
`default_nettype none

package pcipm_pkg;

    typedef enum logic [1:0] {
        PCIPM_D0    = 2'h0,
        PCIPM_D1    = 2'h1,
        PCIPM_D2    = 2'h2,
        PCIPM_D3HOT = 2'h3
    } pcipm_pstate_t;

    // control/status word as seen by software
    typedef struct packed {
        logic          wake_event_status_flag;
        logic [1:0]    data_scale_factor;
        logic [3:0]    data_select;
        logic          wake_event_enable;
        logic [5:0]    reserved;
        pcipm_pstate_t power_state_field;
    } pcipm_pm_control_status_t;

    // bridge support extension byte
    typedef struct packed {
        logic       secondary_bus_pwr_clk_ctrl_en;
        logic       d3hot_secondary_action;
        logic [5:0] reserved;
    } pcipm_bse_t;

    // write request held until both channels have arrived
    typedef struct packed {
        logic [5:0]  index;
        logic [31:0] data;
        logic [3:0]  strb;
    } pcipm_wreq_t;

endpackage

`default_nettype wire

// file: pcipm_regs.svh
// register offsets, field positions, reset values and bus codes of the pm control block
`ifndef PCIPM_REGS_SVH
`define PCIPM_REGS_SVH

// register indices; byte address is four times the index
`define PCIPM_IDX_PM_CONTROL_STATUS        6'h04
`define PCIPM_IDX_BSE          6'h06
`define PCIPM_IDX_DATA         6'h07
`define PCIPM_IDX_IRQ_STATUS   6'h08
`define PCIPM_IDX_IRQ_MASK     6'h09
`define PCIPM_IDX_FUNC_STATUS  6'h0A

// control/status word field positions
`define PCIPM_BIT_WAKE_STATUS  15
`define PCIPM_BIT_WAKE_ENABLE  8
`define PCIPM_SEL_LSB          9
`define PCIPM_SEL_MSB          12
`define PCIPM_PS_LSB           0
`define PCIPM_PS_MSB           1

// bridge extension byte field positions
`define PCIPM_BIT_SECONDARY_BUS_PWR_CLK_CTRL_EN      7
`define PCIPM_BIT_D3HOT_ACT    6

// interrupt status bits
`define PCIPM_IRQ_WAKE         0
`define PCIPM_IRQ_PS_CHANGE    1
`define PCIPM_IRQ_W            2

// reset values
`define PCIPM_PM_CONTROL_STATUS_RESET      16'h0000
`define PCIPM_BSE_RESET        8'h00
`define PCIPM_IRQ_RESET        2'h0

// axi4-lite responses
`define PCIPM_RESP_OKAY        2'h0
`define PCIPM_RESP_SLVERR      2'h2

`endif

// file: pcipm_strap_sampler.sv
// captures the cold-wake support strap once after power-on reset
`default_nettype none

module pcipm_strap_sampler (
    // clock and power-on reset
    input  wire logic clk,
    input  wire logic pwr_on_reset,
    input  wire logic ce,
    // strap
    input  wire logic cold_wake_support_strap,
    output logic      cold_wake_supported,
    output logic      strap_taken
);

    // strap is read after release so the reset itself stays a constant
    always_ff @(posedge clk) begin
        if (ce) begin
            if (pwr_on_reset) begin
                cold_wake_supported <= 1'b0;
                strap_taken         <= 1'b0;
            end else if (!strap_taken) begin
                cold_wake_supported <= cold_wake_support_strap;
                strap_taken         <= 1'b1;
            end
        end
    end

endmodule

`default_nettype wire
